// [lhr_limp_home.sv]
// Limp-home supervisor: reset event counter, force bit and open-drain pin
`timescale 1ns/10ps
`include "lhr_params.svh"

module lhr_limp_home #(
  parameter int unsigned LIMP_DELAY_CYC = `LHR_LIMP_DELAY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire lhr_pkg::lhr_reg_req_t reg_req_i,
  output lhr_pkg::lhr_reg_rsp_t reg_rsp_o,
  input wire lhr_pkg::lhr_sbc_state_t sbc_state_i,
  output logic limp_o,
  output logic limp_oe_n_o,
  output logic [`LHR_CNT_HI:0] reset_event_counter_o
);
  import lhr_pkg::*;

  logic fallback_force_bit_q, fallback_force_bit_d;
  logic [`LHR_CNT_HI:0] reset_event_counter_q, reset_event_counter_d;
  logic reset_mode_prev_q, reset_mode_prev_d;
  logic limp_q, limp_d;
  logic limp_oe_n_q, limp_oe_n_d;
  lhr_reg_rsp_t rsp_q, rsp_d;

  logic reset_entry;
  logic ctrl_wr;
  logic ctrl_rd;
  logic fn_mode;
  logic off_mode;
  logic wr_force;
  logic [`LHR_CNT_HI:0] wr_count;
  logic [`LHR_NUM_TIMERS-1:0] tmr_cond;
  logic [`LHR_NUM_TIMERS-1:0] tmr_trip;
  logic wrap_trip;
  logic any_trip;

  assign fn_mode = sbc_state_i.forced_normal_select;
  assign off_mode = sbc_state_i.off_mode;
  // Every entry outside forced normal and Off mode counts, including the pass through Reset after sleep exit
  assign reset_entry = sbc_state_i.reset_mode && !reset_mode_prev_q;
  assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == `LHR_FS_CTRL_ADDR;
  assign ctrl_rd = reg_req_i.rd && reg_req_i.addr == `LHR_FS_CTRL_ADDR;
  assign wr_force = reg_req_i.wdata[`LHR_FORCE_BIT];
  assign wr_count = reg_req_i.wdata[`LHR_CNT_HI:`LHR_CNT_LO];

  assign tmr_cond[`LHR_TMR_OVERTEMP] = sbc_state_i.overtemp;
  assign tmr_cond[`LHR_TMR_RESET_LONG] = sbc_state_i.reset_mode;

  // Both long-duration watchers share one delay; disabled in forced normal
  // and in Off mode so that they restart cleanly afterwards.
  generate
    for (genvar g = 0; g < `LHR_NUM_TIMERS; g++) begin : g_tmr
      lhr_persist_timer #(
        .DELAY_CYC(LIMP_DELAY_CYC)
      ) u_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(!fn_mode && !off_mode),
        .cond_i(tmr_cond[g]),
        .trip_o(tmr_trip[g])
      );
    end
  endgenerate

  assign wrap_trip = reset_entry && !fn_mode &&
                     reset_event_counter_q == `LHR_CNT_FULL;
  assign any_trip = wrap_trip ||
                    tmr_trip[`LHR_TMR_OVERTEMP] ||
                    tmr_trip[`LHR_TMR_RESET_LONG];

  // Counter and force bit. Hardware events win over a same-cycle write so
  // that a trip cannot be lost to a host clearing the bit at that moment.
  always_comb begin
    reset_event_counter_d = reset_event_counter_q;
    fallback_force_bit_d = fallback_force_bit_q;
    reset_mode_prev_d = sbc_state_i.reset_mode;
    if (off_mode) begin
      reset_event_counter_d = `LHR_CNT_RESET;
      fallback_force_bit_d = 1'b0;
    end else if (fn_mode) begin
      fallback_force_bit_d = 1'b0;
      if (ctrl_wr) begin
        reset_event_counter_d = wr_count;
      end
    end else begin
      if (reset_entry) begin
        // Two-bit add wraps 11 to 00 by itself
        reset_event_counter_d = reset_event_counter_q + `LHR_CNT_STEP;
      end else if (ctrl_wr) begin
        reset_event_counter_d = wr_count;
      end
      if (any_trip) begin
        fallback_force_bit_d = 1'b1;
      end else if (ctrl_wr) begin
        fallback_force_bit_d = wr_force;
      end
    end
  end

  // Pin registers follow the next value so pin and bit change on one edge
  always_comb begin
    limp_d = 1'b0;
    limp_oe_n_d = !fallback_force_bit_d;
  end

  // Register read port; reserved and unmapped bits read as zero
  always_comb begin
    rsp_d.valid = reg_req_i.rd;
    rsp_d.rdata = `LHR_READ_ZERO;
    if (ctrl_rd) begin
      rsp_d.rdata = {`LHR_RSVD_ZERO, fallback_force_bit_q,
                     reset_event_counter_q};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reset_event_counter_q <= `LHR_CNT_RESET;
      fallback_force_bit_q <= 1'b0;
      reset_mode_prev_q <= 1'b0;
      limp_q <= 1'b0;
      limp_oe_n_q <= 1'b1;
      rsp_q <= '0;
    end else begin
      reset_event_counter_q <= reset_event_counter_d;
      fallback_force_bit_q <= fallback_force_bit_d;
      reset_mode_prev_q <= reset_mode_prev_d;
      limp_q <= limp_d;
      limp_oe_n_q <= limp_oe_n_d;
      rsp_q <= rsp_d;
    end
  end

  assign limp_o = limp_q;
  assign limp_oe_n_o = limp_oe_n_q;
  assign reg_rsp_o = rsp_q;
  assign reset_event_counter_o = reset_event_counter_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_entry_live;
    reset_entry && !fn_mode && !off_mode;
  endsequence

  sequence s_entry_at_full;
    s_entry_live ##0 reset_event_counter_q == `LHR_CNT_FULL;
  endsequence

  sequence s_wrap_result;
    fallback_force_bit_q && reset_event_counter_q == `LHR_CNT_RESET;
  endsequence

  pin_never_high_a: assert property (
    limp_o == 1'b0)
    else $error("Limp pin driven high");

  pin_follows_bit_a: assert property (
    limp_oe_n_o == !fallback_force_bit_q)
    else $error("Limp pin does not follow force bit");

  count_step_a: assert property (
    s_entry_live ##0 reset_event_counter_q != `LHR_CNT_FULL |=>
    reset_event_counter_q == $past(reset_event_counter_q) + `LHR_CNT_STEP)
    else $error("Counter did not advance on reset entry");

  wrap_sets_force_a: assert property (
    s_entry_at_full |=> s_wrap_result ##0 !limp_oe_n_o)
    else $error("Wrap did not set force bit and clear counter");

  sw_set_force_a: assert property (
    ctrl_wr && wr_force && !fn_mode && !off_mode |=>
    fallback_force_bit_q && !limp_oe_n_o)
    else $error("Host write did not force limp");

  sw_release_a: assert property (
    ctrl_wr && !wr_force && !any_trip && !off_mode |=> !fallback_force_bit_q
    ##0 limp_oe_n_o)
    else $error("Host clear did not release limp");

  off_clears_a: assert property (
    off_mode |=> reset_event_counter_q == `LHR_CNT_RESET &&
    !fallback_force_bit_q && limp_oe_n_o)
    else $error("Leaving Off mode did not clear state");

  preset_count_a: assert property (
    ctrl_wr && !off_mode && !(reset_entry && !fn_mode) |=>
    reset_event_counter_q == $past(wr_count))
    else $error("Counter preset not taken");

  temp_trip_a: assert property (
    tmr_trip[`LHR_TMR_OVERTEMP] && !off_mode && !fn_mode |=>
    fallback_force_bit_q)
    else $error("Overtemperature trip did not force limp");

  long_reset_a: assert property (
    tmr_trip[`LHR_TMR_RESET_LONG] && !off_mode && !fn_mode |=>
    fallback_force_bit_q)
    else $error("Long reset trip did not force limp");

  forced_normal_a: assert property (
    fn_mode && !off_mode && !ctrl_wr |=> !fallback_force_bit_q &&
    limp_oe_n_o && $stable(reset_event_counter_q))
    else $error("Forced normal did not disable limp-home");

  read_map_a: assert property (
    ctrl_rd |=> reg_rsp_o.valid && reg_rsp_o.rdata ==
    {`LHR_RSVD_ZERO, $past(fallback_force_bit_q),
     $past(reset_event_counter_q)})
    else $error("Control register read mismatch");

endmodule // lhr_limp_home

// [lhr_params.svh]
// Constants for the limp-home reset supervisor: map, fields, reset values, timing
`ifndef LHR_PARAMS_SVH
`define LHR_PARAMS_SVH

`define LHR_ADDR_W 7
`define LHR_DATA_W 8
`define LHR_FS_CTRL_ADDR 7'h02
`define LHR_FORCE_BIT 2
`define LHR_CNT_HI 1
`define LHR_CNT_LO 0
`define LHR_CNT_RESET 2'h0
`define LHR_CNT_FULL 2'h3
`define LHR_CNT_STEP 2'h1
`define LHR_RSVD_ZERO 5'h00
`define LHR_READ_ZERO 8'h00
`define LHR_CLK_MHZ 250
`define LHR_LIMP_DELAY_NS 1000000
`define LHR_LIMP_DELAY_CYC (`LHR_LIMP_DELAY_NS * `LHR_CLK_MHZ / 1000)
`define LHR_NUM_TIMERS 2
`define LHR_TMR_OVERTEMP 0
`define LHR_TMR_RESET_LONG 1

`endif

// [lhr_pkg.sv]
// Types shared by the limp-home reset supervisor and its helpers
`include "lhr_params.svh"

package lhr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`LHR_ADDR_W-1:0] addr;
    logic [`LHR_DATA_W-1:0] wdata;
  } lhr_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [`LHR_DATA_W-1:0] rdata;
  } lhr_reg_rsp_t;

  typedef struct packed {
    logic reset_mode;
    logic off_mode;
    logic overtemp;
    logic forced_normal_select;
  } lhr_sbc_state_t;

endpackage : lhr_pkg

// [lhr_persist_timer.sv]
// Persistence timer: one pulse once a condition has held longer than a delay
`timescale 1ns/10ps
`include "lhr_params.svh"

module lhr_persist_timer #(
  parameter int unsigned DELAY_CYC = `LHR_LIMP_DELAY_CYC,
  parameter int unsigned CNT_W = $clog2(DELAY_CYC + 2)
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic cond_i,
  output logic trip_o
);
  import lhr_pkg::*;

  localparam logic [CNT_W-1:0] DELAY_MAX = CNT_W'(DELAY_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic trip_q, trip_d;

  // Fires once per continuous episode, so a software clear is not undone
  // by a condition that is still present.
  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    trip_d = 1'b0;
    if (!enable_i || !cond_i) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (cnt_q != DELAY_MAX) begin
      cnt_d = cnt_q + CNT_ONE;
    end else if (!done_q) begin
      trip_d = 1'b1;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
      trip_q <= trip_d;
    end
  end

  assign trip_o = trip_q;

  // Trip only after the full delay with the condition still present
  timer_trip_cause_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    trip_q |-> $past(cnt_q) == DELAY_MAX && $past(cond_i) && $past(enable_i))
    else $error("Timer tripped without full persistence");

endmodule // lhr_persist_timer

// [lhr_limp_partner.sv]
// Limp-home hardware model: pulled-up open-drain line and its active flag
`timescale 1ns/10ps

module lhr_limp_partner (
  input wire logic limp_i,
  input wire logic limp_oe_n_i,
  output logic line_o,
  output logic limp_active_o
);
  // Pull-up wins whenever the device lets go of the line
  assign line_o = limp_oe_n_i ? 1'b1 : limp_i;
  assign limp_active_o = !line_o;
endmodule // lhr_limp_partner

// [lhr_limp_home_tb_top.sv]
// Testbench for the limp-home reset supervisor
`timescale 1ns/10ps
`include "lhr_params.svh"

module lhr_limp_home_tb_top;
  import lhr_pkg::*;
  // Short delay keeps the persistence scenarios brief
  localparam int unsigned DLY = 5;
  logic sys_clk_i;
  logic rst_n_i;
  lhr_reg_req_t req;
  lhr_reg_rsp_t rsp;
  lhr_sbc_state_t st;
  logic limp;
  logic limp_oe_n;
  logic line;
  logic active;
  logic [1:0] cnt;
  int errors;
  int comparisons;

  lhr_limp_home #(.LIMP_DELAY_CYC(DLY)) i_lhr_limp_home (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
    .reg_rsp_o(rsp), .sbc_state_i(st), .limp_o(limp),
    .limp_oe_n_o(limp_oe_n), .reset_event_counter_o(cnt));

  lhr_limp_partner i_lhr_limp_partner (
    .limp_i(limp), .limp_oe_n_i(limp_oe_n), .line_o(line),
    .limp_active_o(active));

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk_i);
    req.wr = 1'b0;
    idle(2);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk_i);
    req.rd = 1'b0;
    chk({7'h00, rsp.valid}, 8'h01);
    chk(rsp.rdata, exp);
  endtask

  task automatic pin(input logic exp);
    chk({6'h00, line, active}, {6'h00, exp, !exp});
  endtask

  // Mask order follows the state struct: reset, off, overtemp, forced normal
  task automatic hold(input logic [3:0] m, input int n);
    @(negedge sys_clk_i);
    st = lhr_sbc_state_t'(st | m);
    idle(n);
    st = lhr_sbc_state_t'(st & ~m);
    idle(2);
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // A hang counts as a mismatch and goes to the same report
  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    req = '0;
    st = '0;
    idle(4);
    rst_n_i = 1'b1;
    idle(1);
    pin(1'b1);
    rd(7'h02, 8'h00);
    wr(7'h02, 8'hFF);
    rd(7'h02, 8'h07);
    pin(1'b0);
    wr(7'h02, 8'h00);
    pin(1'b1);
    wr(7'h05, 8'h04);
    rd(7'h05, 8'h00);
    pin(1'b1);
    wr(7'h02, 8'h04);
    pin(1'b0);
    wr(7'h02, 8'h00);
    for (int i = 1; i <= 4; i++) begin
      hold(4'h8, 1);
      rd(7'h02, (i == 4) ? 8'h04 : 8'(i));
      chk({6'h00, cnt}, (i == 4) ? 8'h00 : 8'(i));
    end
    pin(1'b0);
    wr(7'h02, 8'h03);
    pin(1'b1);
    hold(4'h8, 1);
    rd(7'h02, 8'h04);
    wr(7'h02, 8'h00);
    // Two cycles short of the trip point must not set the force bit
    hold(4'h2, DLY - 1);
    rd(7'h02, 8'h00);
    hold(4'h2, DLY + 4);
    rd(7'h02, 8'h04);
    wr(7'h02, 8'h00);
    hold(4'h8, DLY + 4);
    rd(7'h02, 8'h05);
    wr(7'h02, 8'h00);
    st.forced_normal_select = 1'b1;
    idle(2);
    wr(7'h02, 8'h07);
    rd(7'h02, 8'h03);
    hold(4'h8, 1);
    rd(7'h02, 8'h03);
    hold(4'h2, DLY + 4);
    rd(7'h02, 8'h03);
    pin(1'b1);
    st.forced_normal_select = 1'b0;
    idle(2);
    wr(7'h02, 8'h07);
    pin(1'b0);
    hold(4'h4, 2);
    rd(7'h02, 8'h00);
    chk({6'h00, cnt}, 8'h00);
    pin(1'b1);
    close_out();
  end
endmodule // lhr_limp_home_tb_top
